// file: logic/smbus_cfg_pkg.sv
// constants, field layout, defaults and state types of the smbus configuration port
package smbus_cfg_pkg;

  localparam logic [4:0] ADDR_FIXED     = 5'h1A;
  localparam logic [6:0] OFS_IDENTITY   = 7'h00;
  localparam logic [6:0] OFS_CFG_FIRST  = 7'h01;
  localparam logic [6:0] OFS_CFG_LAST   = 7'h0A;
  localparam logic [6:0] OFS_STATUS     = 7'h18;
  localparam logic [6:0] OFS_NVM_CTRL   = 7'h1A;
  localparam int         BIT_NVM_BUSY   = 7;
  localparam int         BIT_NVM_START  = 7;
  localparam int         BIT_CMD_SINGLE = 7;
  localparam int         BIT_REF_HIGH   = 0;
  localparam int         LSB_FB_HIGH    = 1;
  localparam int         LSB_SELECT3    = 5;
  localparam int         LSB_CFG_ZERO   = 0;
  localparam int         LSB_CFG_ONE    = 2;
  localparam int         BIT_INPUT_CLK  = 4;
  localparam logic [3:0] NVM_FIRST      = 4'h1;
  localparam logic [3:0] NVM_LAST       = 4'hA;
  // identity nibbles: arbitrary values
  localparam logic [3:0] REVISION_ID    = 4'h2;
  localparam logic [3:0] VENDOR_ID      = 4'h5;
  // reset contents of registers 10 down to 1
  localparam logic [10:1][7:0] CFG_DEFAULT =
    {8'h00, 8'h01, 8'h08, 8'h77, 8'h00, 8'h08, 8'h1B, 8'h00, 8'h08, 8'h01};

  typedef enum logic [10:0]
  {
    ST_IDLE      = 11'h001,
    ST_ADDR      = 11'h002,
    ST_ADDR_ACK  = 11'h004,
    ST_CMD       = 11'h008,
    ST_CMD_ACK   = 11'h010,
    ST_COUNT     = 11'h020,
    ST_COUNT_ACK = 11'h040,
    ST_WDATA     = 11'h080,
    ST_WDATA_ACK = 11'h100,
    ST_RDATA     = 11'h200,
    ST_RDATA_ACK = 11'h400
  } port_state_t;

  typedef enum logic [1:0]
  {
    NV_IDLE = 2'h1,
    NV_COPY = 2'h2
  } nvm_state_t;

endpackage : smbus_cfg_pkg

// file: logic/bus_condition_detect.sv
// edge, start and stop detection on the two-wire bus
`timescale 1ns/10ps
module bus_condition_detect
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_seen,
  output logic      stop_seen
);

  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;

endmodule : bus_condition_detect

// file: logic/nvm_copy_sequencer.sv
// copies a snapshot of the configuration bytes into nvm, one byte per handshake
`timescale 1ns/10ps
module nvm_copy_sequencer
  import smbus_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        copy_start,
  input  wire logic [79:0] image,
  input  wire logic        nvm_wr_ready,
  output logic             nvm_busy,
  output logic             nvm_wr_valid,
  output logic [3:0]       nvm_wr_addr,
  output logic [7:0]       nvm_wr_data
);

  nvm_state_t  state;
  logic [79:0] snap;

  // snapshot taken at the start so the copy matches the trigger moment
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state       <= NV_IDLE;
      snap        <= '0;
      nvm_wr_addr <= NVM_FIRST;
      nvm_wr_data <= 8'h00;
    end
    else
    begin
      unique case (state)
        NV_IDLE:
        begin
          if (copy_start)
          begin
            snap        <= image;
            nvm_wr_addr <= NVM_FIRST;
            nvm_wr_data <= image[7:0];
            state       <= NV_COPY;
          end
        end
        NV_COPY:
        begin
          if (nvm_wr_ready)
          begin
            if (nvm_wr_addr == NVM_LAST)
              state <= NV_IDLE;
            else
            begin
              nvm_wr_addr <= nvm_wr_addr + 4'h1;
              nvm_wr_data <= snap[8 * nvm_wr_addr +: 8];
            end
          end
        end
      endcase
    end
  end

  assign nvm_busy     = (state == NV_COPY);
  assign nvm_wr_valid = (state == NV_COPY);

endmodule : nvm_copy_sequencer

// file: logic/smbus_config_register_port.sv
// smbus target with the configuration register file of a three-pll synthesizer
`timescale 1ns/10ps
module smbus_config_register_port
  import smbus_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        nvm_wr_ready,
  output logic             nvm_wr_valid,
  output logic [3:0]       nvm_wr_addr,
  output logic [7:0]       nvm_wr_data,
  output logic             nvm_write_in_progress,
  output logic [8:0]       pll1_ref_div,
  output logic [11:0]      pll1_fb_div,
  output logic [8:0]       pll2_ref_div,
  output logic [11:0]      pll2_fb_div,
  output logic [8:0]       pll3_ref_div,
  output logic [11:0]      pll3_fb_div,
  output logic [2:0]       first_pll_bypass_mux,
  output logic [2:0]       vco_range,
  output logic [2:0]       post_divider_zero_sel,
  output logic [2:0]       post_divider_one_sel,
  output logic             input_clock_select,
  output logic [1:0]       config_input_zero,
  output logic [1:0]       config_input_one
);

  function automatic logic [8:0] ref_div(input logic [7:0] high, input logic [7:0] low);
    ref_div = {high[BIT_REF_HIGH], low};
  endfunction : ref_div

  function automatic logic [11:0] fb_div(input logic [7:0] high, input logic [7:0] low);
    fb_div = {high[LSB_FB_HIGH +: 4], low};
  endfunction : fb_div

  // block transfers step one register per byte
  function automatic logic [6:0] next_index(input logic [6:0] at);
    next_index = at + 7'h01;
  endfunction : next_index

  port_state_t state;
  logic [7:0]  regs [1:10];
  logic [7:0]  shreg;
  logic [2:0]  bitcnt;
  logic        byte_full;
  logic [6:0]  index;
  logic        single_mode;
  logic        rw_read;
  logic        wrote_once;
  logic        master_nack;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;

  logic        receiving;
  logic        addr_select_low;
  logic        addr_select_high;
  logic        addr_match;
  logic        in_cfg;
  logic [7:0]  read_byte;
  logic [7:0]  read_load;
  logic        data_ack_ok;
  logic        reg_write;
  logic        nvm_start;
  logic [79:0] image;

  bus_condition_detect u_detect
  (
    .clk        (clk),
    .reset      (reset),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_seen (start_seen),
    .stop_seen  (stop_seen)
  );

  nvm_copy_sequencer u_nvm
  (
    .clk          (clk),
    .reset        (reset),
    .copy_start   (nvm_start),
    .image        (image),
    .nvm_wr_ready (nvm_wr_ready),
    .nvm_busy     (nvm_write_in_progress),
    .nvm_wr_valid (nvm_wr_valid),
    .nvm_wr_addr  (nvm_wr_addr),
    .nvm_wr_data  (nvm_wr_data)
  );

  // address match and read selection
  assign receiving        = (state == ST_ADDR) | (state == ST_CMD) |
                            (state == ST_COUNT) | (state == ST_WDATA);
  assign addr_select_low  = regs[10][LSB_CFG_ZERO];
  assign addr_select_high = regs[10][LSB_CFG_ONE];
  assign addr_match       = (shreg[7:1] == {ADDR_FIXED, addr_select_high, addr_select_low});
  assign in_cfg           = (index >= OFS_CFG_FIRST) && (index <= OFS_CFG_LAST);
  assign read_byte        = in_cfg ? regs[index[3:0]] :
                            (index == OFS_IDENTITY && single_mode) ? {REVISION_ID, VENDOR_ID} :
                            (index == OFS_STATUS) ? {nvm_write_in_progress, 7'h00} :
                            8'h00;
  // bit 7 goes out at once, the rest waits in the shifter
  assign read_load        = {read_byte[6:0], 1'b0};
  assign data_ack_ok      = ~(single_mode & wrote_once);
  // writes land at the rising clock of the ack; ignored while nvm copy runs
  assign reg_write        = scl_rise & (state == ST_WDATA_ACK) & ~nvm_write_in_progress;
  assign nvm_start        = reg_write & (index == OFS_NVM_CTRL) & shreg[BIT_NVM_START];
  assign sda_out          = 1'b0;

  always_comb
  begin
    image = '0;
    for (int i = 1; i <= 10; i++)
      image[8 * (i - 1) +: 8] = regs[i];
  end

  // register file, defaults at reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 1; i <= 10; i++)
        regs[i] <= CFG_DEFAULT[i];
    end
    else if (reg_write && in_cfg)
      regs[index[3:0]] <= shreg;
  end

  // bit level protocol engine
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state       <= ST_IDLE;
      shreg       <= 8'h00;
      bitcnt      <= 3'h0;
      byte_full   <= 1'b0;
      index       <= 7'h00;
      single_mode <= 1'b0;
      rw_read     <= 1'b0;
      wrote_once  <= 1'b0;
      master_nack <= 1'b0;
      sda_oe      <= 1'b0;
    end
    else if (stop_seen)
    begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_seen)
    begin
      state     <= ST_ADDR;
      bitcnt    <= 3'h0;
      byte_full <= 1'b0;
      sda_oe    <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (receiving)
      begin
        shreg     <= {shreg[6:0], sda_in};
        bitcnt    <= bitcnt + 3'h1;
        byte_full <= (bitcnt == 3'h7);
      end
      else if (state == ST_WDATA_ACK)
      begin
        wrote_once <= 1'b1;
        if (!single_mode)
          index <= next_index(index);
      end
      else if (state == ST_RDATA_ACK)
      begin
        master_nack <= sda_in;
        if (!sda_in && !single_mode)
          index <= next_index(index);
      end
    end
    else if (scl_fall)
    begin
      unique case (state)
        ST_IDLE:
        begin
          sda_oe <= 1'b0;
        end
        ST_ADDR, ST_CMD, ST_COUNT, ST_WDATA:
        begin
          if (byte_full)
          begin
            byte_full <= 1'b0;
            bitcnt    <= 3'h0;
            if (state == ST_ADDR)
            begin
              if (addr_match)
              begin
                state   <= ST_ADDR_ACK;
                rw_read <= shreg[0];
                sda_oe  <= 1'b1;
              end
              else
                state <= ST_IDLE;
            end
            else if (state == ST_CMD)
            begin
              single_mode <= shreg[BIT_CMD_SINGLE];
              index       <= shreg[6:0];
              wrote_once  <= 1'b0;
              state       <= ST_CMD_ACK;
              sda_oe      <= 1'b1;
            end
            else if (state == ST_COUNT)
            begin
              state  <= ST_COUNT_ACK;
              sda_oe <= 1'b1;
            end
            else if (data_ack_ok)
            begin
              state  <= ST_WDATA_ACK;
              sda_oe <= 1'b1;
            end
            else
              state <= ST_IDLE;
          end
        end
        ST_ADDR_ACK:
        begin
          if (rw_read)
          begin
            state       <= ST_RDATA;
            shreg       <= read_load;
            sda_oe      <= ~read_byte[7];
            bitcnt      <= 3'h1;
            master_nack <= 1'b0;
          end
          else
          begin
            state  <= ST_CMD;
            sda_oe <= 1'b0;
          end
        end
        ST_CMD_ACK:
        begin
          state  <= single_mode ? ST_WDATA : ST_COUNT;
          sda_oe <= 1'b0;
        end
        ST_COUNT_ACK, ST_WDATA_ACK:
        begin
          state  <= ST_WDATA;
          sda_oe <= 1'b0;
        end
        ST_RDATA:
        begin
          if (bitcnt == 3'h0)
          begin
            state  <= ST_RDATA_ACK;
            sda_oe <= 1'b0;
          end
          else
          begin
            sda_oe <= ~shreg[7];
            shreg  <= {shreg[6:0], 1'b0};
            bitcnt <= bitcnt + 3'h1;
          end
        end
        ST_RDATA_ACK:
        begin
          if (master_nack)
          begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
          else
          begin
            state  <= ST_RDATA;
            shreg  <= read_load;
            sda_oe <= ~read_byte[7];
            bitcnt <= 3'h1;
          end
        end
      endcase
    end
  end

  // configuration fields toward the synthesizer
  assign pll1_ref_div          = ref_div(regs[3], regs[1]);
  assign pll1_fb_div           = fb_div(regs[3], regs[2]);
  assign first_pll_bypass_mux  = regs[3][LSB_SELECT3 +: 3];
  assign pll2_ref_div          = ref_div(regs[6], regs[4]);
  assign pll2_fb_div           = fb_div(regs[6], regs[5]);
  assign vco_range             = regs[6][LSB_SELECT3 +: 3];
  assign pll3_ref_div          = ref_div(regs[9], regs[7]);
  assign pll3_fb_div           = fb_div(regs[9], regs[8]);
  assign post_divider_zero_sel = regs[9][LSB_SELECT3 +: 3];
  assign post_divider_one_sel  = regs[10][LSB_SELECT3 +: 3];
  assign input_clock_select    = regs[10][BIT_INPUT_CLK];
  assign config_input_zero     = regs[10][LSB_CFG_ZERO +: 2];
  assign config_input_one      = regs[10][LSB_CFG_ONE +: 2];

endmodule : smbus_config_register_port

// file: test/smbus_port_asserts.sv
// concurrent checks on the ports of the smbus configuration port
`timescale 1ns/10ps
module smbus_port_asserts
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       scl_in,
  input  wire logic       sda_out,
  input  wire logic       sda_oe,
  input  wire logic       nvm_wr_ready,
  input  wire logic       nvm_wr_valid,
  input  wire logic [3:0] nvm_wr_addr,
  input  wire logic [7:0] nvm_wr_data,
  input  wire logic       nvm_write_in_progress,
  input  wire logic [8:0] pll1_ref_div,
  input  wire logic [1:0] config_input_zero
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // one byte taken by the nvm side
  sequence handoff;
    nvm_wr_valid && nvm_wr_ready;
  endsequence
  sequence last_handoff;
    handoff ##0 (nvm_wr_addr == 4'hA);
  endsequence
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_cfg_on_ack: assert property ($changed(pll1_ref_div) || $changed(config_input_zero) |-> scl_in)
    else $error("register changed outside ack clock high");
  a_busy_flag: assert property ($fell(nvm_write_in_progress) |->
    $past(nvm_wr_ready) && $past(nvm_wr_addr) == 4'hA)
    else $error("busy flag dropped before last byte");
  a_copy_start: assert property ($rose(nvm_write_in_progress) |-> scl_in && nvm_wr_addr == 4'h1)
    else $error("copy start wrong");
  a_nvm_range: assert property (nvm_wr_valid |-> nvm_wr_addr >= 4'h1 && nvm_wr_addr <= 4'hA)
    else $error("copy index out of range");
  a_nvm_step: assert property (handoff ##0 (nvm_wr_addr != 4'hA) |=>
    nvm_wr_valid && nvm_wr_addr == $past(nvm_wr_addr) + 4'h1)
    else $error("copy index did not advance");
  a_nvm_end: assert property (last_handoff |=> !nvm_wr_valid)
    else $error("copy did not end after last byte");
  a_nvm_hold: assert property (nvm_wr_valid && !nvm_wr_ready |=>
    nvm_wr_valid && $stable(nvm_wr_addr) && $stable(nvm_wr_data))
    else $error("offered byte changed while stalled");
endmodule : smbus_port_asserts

bind smbus_config_register_port smbus_port_asserts u_asserts
(
  .clk(clk), .reset(reset), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .nvm_wr_ready(nvm_wr_ready), .nvm_wr_valid(nvm_wr_valid), .nvm_wr_addr(nvm_wr_addr),
  .nvm_wr_data(nvm_wr_data), .nvm_write_in_progress(nvm_write_in_progress),
  .pll1_ref_div(pll1_ref_div), .config_input_zero(config_input_zero)
);

// file: test/smbus_host_model.sv
// smbus host controller model driving clock and open-drain data
`timescale 1ns/10ps
module smbus_host_model
(
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  localparam int HALF = 4;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(posedge clk);
  endtask : tick
  // start or repeated start: data falls while clock high
  task automatic start_cond();
    sda_low <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start_cond
  task automatic stop_cond();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b0;
    tick();
  endtask : stop_cond
  // data set while clock low, sampled at clock high, released line reads high
  task automatic bit_cycle(input logic b, output logic s);
    sda_low <= !b;
    tick();
    scl <= 1'b1;
    tick();
    s = sda_in;
    scl <= 1'b0;
    tick();
  endtask : bit_cycle
  task automatic send(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    acked = !s;
  endtask : send
  // host nack on the last byte ends a read
  task automatic recv(output logic [7:0] b, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b1, b[i]);
    bit_cycle(!ack, s);
  endtask : recv
endmodule : smbus_host_model

// file: test/tb.sv
// self-checking bench for the smbus configuration port
`timescale 1ns/10ps
`define CHK(got, want) begin checked++; if ((got) !== (want)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, (got), (want)); end end
module tb;
  import smbus_cfg_pkg::*;
  logic        clk, reset, scl, sda_low, sda, nvm_wr_ready, sda_out, sda_oe;
  logic        nvm_wr_valid, nvm_write_in_progress, ics, busy_exp, stall;
  logic [3:0]  nvm_wr_addr, nv_next;
  logic [7:0]  nvm_wr_data;
  logic [8:0]  p1r, p2r, p3r;
  logic [11:0] p1f, p2f, p3f;
  logic [2:0]  mux, vco, pd0, pd1;
  logic [1:0]  ci0, ci1;
  logic [31:0] rnd, nrnd;
  logic [7:0]  exp_reg [0:10];
  logic [7:0]  wbuf [0:7];
  logic [6:0]  dev_addr;
  int          error_cnt, checked, cycles;
  assign sda = !(sda_low || sda_oe);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  smbus_host_model u_host (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
  smbus_config_register_port u_smbus_config_register_port
  (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .nvm_wr_ready(nvm_wr_ready), .nvm_wr_valid(nvm_wr_valid), .nvm_wr_addr(nvm_wr_addr),
    .nvm_wr_data(nvm_wr_data), .nvm_write_in_progress(nvm_write_in_progress),
    .pll1_ref_div(p1r), .pll1_fb_div(p1f), .pll2_ref_div(p2r), .pll2_fb_div(p2f),
    .pll3_ref_div(p3r), .pll3_fb_div(p3f), .first_pll_bypass_mux(mux), .vco_range(vco),
    .post_divider_zero_sel(pd0), .post_divider_one_sel(pd1), .input_clock_select(ics),
    .config_input_zero(ci0), .config_input_one(ci1)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] exp_rd(input int idx, input logic single);
    if (idx == 0)
      return single ? {REVISION_ID, VENDOR_ID} : 8'h00;
    if (idx <= 10)
      return exp_reg[idx];
    return (idx == 24) ? {busy_exp, 7'h00} : 8'h00;
  endfunction : exp_rd
  task automatic wrap_up();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk_out();
    `CHK({p1r, p1f, mux}, {exp_reg[3][0], exp_reg[1], exp_reg[3][4:1], exp_reg[2], exp_reg[3][7:5]})
    `CHK({p2r, p2f, vco}, {exp_reg[6][0], exp_reg[4], exp_reg[6][4:1], exp_reg[5], exp_reg[6][7:5]})
    `CHK({p3r, p3f}, {exp_reg[9][0], exp_reg[7], exp_reg[9][4:1], exp_reg[8]})
    `CHK({pd0, pd1, ics, ci1, ci0}, {exp_reg[9][7:5], exp_reg[10]})
  endtask : chk_out
  // single or block write, single-write bytes after the first expect a nack; outputs checked right after each data ack
  task automatic wr(input logic single, input logic [6:0] idx, input int n);
    logic a;
    u_host.start_cond();
    u_host.send({dev_addr, 1'b0}, a);
    `CHK(a, 1'b1)
    u_host.send({single, idx}, a);
    `CHK(a, 1'b1)
    if (!single)
      u_host.send(8'(n), a);
    for (int i = 0; i < n; i++)
    begin
      u_host.send(wbuf[i], a);
      if (!busy_exp && !(single && i > 0) && idx + i >= 1 && idx + i <= 10)
        exp_reg[idx + i] = wbuf[i];
      `CHK(a, !(single && i > 0))
      chk_out();
    end
    u_host.stop_cond();
  endtask : wr
  task automatic rd(input logic single, input logic [6:0] idx, input int n);
    logic       a;
    logic [7:0] b;
    u_host.start_cond();
    u_host.send({dev_addr, 1'b0}, a);
    u_host.send({single, idx}, a);
    u_host.start_cond();
    u_host.send({dev_addr, 1'b1}, a);
    `CHK(a, 1'b1)
    for (int i = 0; i < n; i++)
    begin
      u_host.recv(b, i < n - 1);
      `CHK(b, exp_rd(single ? int'(idx) : int'(idx) + i, single))
    end
    u_host.stop_cond();
  endtask : rd
  // nvm side: random stalls, each taken byte checked against the register image
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    nrnd = lfsr(nrnd);
    nvm_wr_ready <= !stall && nrnd[0] && nrnd[3];
    if (nvm_wr_valid && nvm_wr_ready)
    begin
      `CHK({nvm_wr_addr, nvm_wr_data}, {nv_next, exp_reg[nv_next]})
      nv_next = nv_next + 4'h1;
    end
    if (cycles == 80000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  initial
  begin
    logic       a;
    logic [6:0] idx;
    int         n;
    reset = 1'b1;
    nvm_wr_ready = 1'b0;
    stall = 1'b0;
    busy_exp = 1'b0;
    nv_next = 4'h1;
    cycles = 0;
    rnd = 32'd65732;
    nrnd = 32'd65732;
    dev_addr = {ADDR_FIXED, 2'b00};
    exp_reg[0] = 8'h00;
    for (int i = 1; i <= 10; i++)
      exp_reg[i] = CFG_DEFAULT[i];
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk_out();
    rd(1'b0, 7'h00, 11);
    rd(1'b1, 7'h00, 1);
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      idx = 7'(1 + rnd % 9);
      wbuf[0] = rnd[15:8];
      wbuf[1] = rnd[23:16];
      wr(1'b1, idx, 1 + k % 2);
      rd(1'b1, idx, 1);
    end
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      idx = 7'(1 + rnd % 6);
      n = 1 + int'(rnd[9:8]);
      for (int i = 0; i < 4; i++)
        wbuf[i] = 8'(rnd >> (8 * i + 3));
      wr(1'b0, idx, n);
      rd(1'b0, 7'h01, 10);
    end
    wbuf[0] = {exp_reg[10][7:4], 4'h5};
    wr(1'b1, 7'h0A, 1);
    dev_addr = {ADDR_FIXED, 2'b11};
    rd(1'b1, 7'h0A, 1);
    u_host.start_cond();
    u_host.send({ADDR_FIXED, 2'b00, 1'b0}, a);
    `CHK(a, 1'b0)
    u_host.stop_cond();
    stall = 1'b1;
    wbuf[0] = 8'h80;
    wr(1'b1, OFS_NVM_CTRL, 1);
    busy_exp = 1'b1;
    rd(1'b1, OFS_STATUS, 1);
    rd(1'b0, 7'h01, 10);
    stall = 1'b0;
    for (int i = 0; i < 2000 && nvm_write_in_progress !== 1'b0; i++)
      @(posedge clk);
    busy_exp = 1'b0;
    `CHK(nv_next, 4'hB)
    rd(1'b1, OFS_STATUS, 1);
    wrap_up();
  end
endmodule : tb
